//--- test/pao_far_model.sv
// Peripheral owners and pad level model facing port B
`timescale 1ns/1ps

module pao_far_model
  import pao_pkg::*;
(
  // Settings from the bench
  input wire logic [31:0] mode,
  input wire logic [7:0] ext_lvl,
  // Pad controls from the block
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  // Owner state and pad level
  output pao_periph_s periph,
  output logic [7:0] pad_in
);
  // Owners raise their own override requests
  assign periph = pao_periph_s'(mode[19:0]);
  // Driver wins, then pull-up; a free pin floats to the outside level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup | ext_lvl));
endmodule : pao_far_model

//--- test/tb_pao_portb.sv
// Self-checking bench for the port B override block
`timescale 1ns/1ps

module tb_pao_portb
  import pao_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] wd = 8'h00;
  logic dws = 1'b0, pws = 1'b0, tws = 1'b0;
  logic drs = 1'b0, prs = 1'b0, irs = 1'b0;
  logic slp = 1'b0, global_pullup_disable = 1'b0;
  logic [7:0] tog = 8'h00, ext = 8'h00;
  logic [31:0] mode = 32'h0;
  pao_periph_s per;
  logic [7:0] rd, raw, pcs, pin, pout, poe, ppu, pie;
  logic [1:0] osc;
  logic [7:0] dir_s = 8'h00, port_s = 8'h00, cm, am;
  logic [39:0] e;
  logic [31:0] r;
  int seed = 32'h66c8df06;
  int err_total = 0;
  int checks = 0;

  // Clock at 100 MHz
  always #5 mclk = ~mclk;

  pao_portb i_pao_portb (
    .MCLK(mclk), .RST_N(rst_n), .WDATA(wd),
    .DIR_WRITE_STROBE(dws), .PORT_WRITE_STROBE(pws),
    .PIN_WRITE_STROBE(tws), .DIR_READ_STROBE(drs),
    .PORT_READ_STROBE(prs), .PIN_READ_STROBE(irs), .RDATA(rd),
    .SLEEP_CLAMP(slp), .GLOBAL_PULLUP_DISABLE(global_pullup_disable), .PERIPH(per),
    .TOGGLE_OVERRIDE_EN(tog), .RAW_PAD_INPUT(raw),
    .PIN_CHANGE_SRC(pcs), .OSC_PATH_EN(osc), .PAD_IN(pin),
    .PAD_OUT(pout), .PAD_OE(poe), .PAD_PULLUP(ppu),
    .PAD_INPUT_EN(pie)
  );

  pao_far_model i_pao_far_model (
    .mode(mode), .ext_lvl(ext), .pad_out(pout), .pad_oe(poe),
    .pad_pullup(ppu), .periph(per), .pad_in(pin)
  );

  // --------------------------------------------------------------
  // Expected pad state: {clock pins, oe, out, pull-up, input en}
  // --------------------------------------------------------------
  function automatic logic [39:0] pads(input pao_periph_s p,
      input logic [7:0] d, input logic [7:0] pt, input logic pu_off,
      input logic sl, input logic [7:0] tg);
    logic c7, c6, m, s;
    logic [7:0] fi, ve, vv, ck;
    c7 = (~p.intrc & ~p.extck) | (p.intrc & p.async_t2 & ~p.ext_clk);
    c6 = ~p.intrc | (p.intrc & p.async_t2);
    m = p.spi_en & p.spi_master;
    s = p.spi_en & ~p.spi_master;
    ck = {c7, c6, 6'h00};
    fi = {c7, c6, s, m, s, 3'b000};
    ve = {2'b00, m, s, m | p.t2_cmp_en, 3'b000};
    vv = {2'b00, p.sck_out, p.miso_out,
      (m & p.mosi_out) | (p.t2_cmp_en & p.t2_cmp_out), 3'b000};
    return {ck, d & ~fi, (ve & vv) | (~ve & (pt ^ tg)),
      ~ck & pt & {8{~pu_off}} & (~d | fi),
      ~ck & ((p.pc_mask & {8{p.pc_group_en}}) | {8{~sl}})};
  endfunction : pads

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Inputs move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  // One-cycle read strobe; RDATA answers at the sampling edge
  task automatic rd_chk(input int sel, input logic [7:0] exp);
    {drs, prs, irs} = 3'b100 >> sel;
    step(1);
    chk(rd, exp);
  endtask : rd_chk

  task automatic report_and_stop();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Guard against a hang
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    step(2);
    chk(poe, 8'h00);
    chk(ppu, 8'h00);
    chk(pie, 8'h00);
    step(1);
    rst_n = 1'b1;
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      // Pass 1: SPI off, timer compare enabled and high on bit 3
      mode = (i == 1) ? ((r & ~32'h0000_8000) | 32'h0000_0600) : r;
      ext = 8'($random(seed));
      tog = 8'($random(seed));
      {slp, global_pullup_disable} = 2'($random(seed));
      r = $random(seed);
      // Pass 0: port write and toggle in one cycle cancel out
      wd = (i == 0) ? 8'hff : (i == 1) ? 8'h08 : r[7:0];
      // Pass 1: bit 3 direction set so the compare output shows
      {dws, pws, tws} = (i == 0) ? 3'b011 : (i == 1) ? 3'b100 : r[10:8];
      if (dws) dir_s = wd;
      if (pws) port_s = wd;
      if (tws) port_s ^= wd;
      step(1);
      {dws, pws, tws} = 3'b000;
      step(5);
      e = pads(per, dir_s, port_s, global_pullup_disable, slp, tog);
      cm = e[39:32];
      // Pin-change on a clock pin is left open
      am = ~(cm & per.pc_mask & {8{per.pc_group_en}});
      chk(poe, e[31:24]);
      chk(pout & poe, e[23:16] & e[31:24]);
      chk(ppu, e[15:8]);
      chk(pie & am, e[7:0] & am);
      chk(raw & am, pin & e[7:0] & am);
      chk(pcs & am, pin & e[7:0] & am & 8'hf8);
      chk({6'h00, osc}, {6'h00, cm[7:6]});
      rd_chk(0, dir_s & ~cm);
      rd_chk(1, port_s & ~cm);
      rd_chk(2, pin & e[7:0] & am & ~cm);
      {drs, prs, irs} = 3'b000;
    end
    report_and_stop();
  end
endmodule : tb_pao_portb

//--- verilog/pao_pkg.sv
// Shared constants and carrier types for the port B alternate-function block
package pao_pkg;

  // ----------------------------------------------------------------------
  // Port geometry and pin positions
  // ----------------------------------------------------------------------
  localparam int PAO_PORT_W = 8;
  localparam int PAO_PB_OSC_OUT = 7;
  localparam int PAO_PB_OSC_IN = 6;
  localparam int PAO_PB_SCK = 5;
  localparam int PAO_PB_MISO = 4;
  localparam int PAO_PB_MOSI = 3;
  localparam int PAO_PC_LO = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PAO_DIR_RST = 8'h00;
  localparam logic [7:0] PAO_PORT_RST = 8'h00;
  localparam logic [7:0] PAO_PIN_RST = 8'h00;
  localparam logic [7:0] PAO_ZERO = 8'h00;

  // Override set that an owning peripheral hands to one pin
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic value_override_en;
    logic value_override_val;
    logic toggle_override_en;
    logic input_en_override_en;
    logic input_en_override_val;
  } pao_ovr_s;

  // Resolved pad controls of one pin
  typedef struct packed {
    logic oe;
    logic out;
    logic pu;
    logic ie;
  } pao_pad_s;

  // Peripheral and clock-system state that owns port B alternate functions
  typedef struct packed {
    logic intrc;
    logic extck;
    logic async_t2;
    logic ext_clk;
    logic spi_en;
    logic spi_master;
    logic sck_out;
    logic miso_out;
    logic mosi_out;
    logic t2_cmp_en;
    logic t2_cmp_out;
    logic pc_group_en;
    logic [7:0] pc_mask;
  } pao_periph_s;

endpackage : pao_pkg

//--- verilog/pao_portb.sv
// Port B pin logic with alternate-function overrides for bits 7 to 3
//
// What this block does
// - Pull-up override enable set: pull-up equals override value, nothing else.
// - Without pull-up override, pull-up on only for direction 0, port 1, disable 0.
// - Driver enable follows direction override value, else the direction bit.
// - Driven value is the value override when enabled, else the port bit.
// - Toggle override inverts the port bit on its way to the pad.
// - Input enable follows its override, else running or sleep clamp state.
// - Raw input taken after the clamp, before the port synchronizer.
// - Strobes shared per port; clock, clamp and pull-up disable global.
// - Each override set comes from the owning peripheral's own function.
// - Bit 7 as clock pin is no I/O; its bits read zero.
// - Bit 6 as clock pin is no I/O; its bits read zero.
// - Bit 6 carries the chip oscillator except with internal RC clock.
// - Timer oscillator pins only with internal RC and async timer clocking.
// - Async timer-2 with external clock clear: bit 7 is oscillator output.
// - Async timer-2 clocking: bit 6 becomes oscillator amplifier input.
// - SPI slave forces clock pin to input; master uses direction bit.
// - SPI master forces master-input pin to input; slave uses direction.
// - SPI slave forces master-output pin to input; master uses direction.
// - Pull-up of an SPI-forced input still follows its port bit.
// - Bits 7 to 3 are pin-change sources numbered by their bit.
// - Direction one drives port bit; zero is input, port bit one pulls up.
// - Writing one to a pin-input bit inverts the port bit.
`timescale 1ns/1ps

module pao_portb
  import pao_pkg::*;
#(
  parameter int PORT_W = PAO_PORT_W
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Shared port strobes and write data
  input wire logic [7:0] WDATA,
  input wire logic DIR_WRITE_STROBE,
  input wire logic PORT_WRITE_STROBE,
  input wire logic PIN_WRITE_STROBE,
  input wire logic DIR_READ_STROBE,
  input wire logic PORT_READ_STROBE,
  input wire logic PIN_READ_STROBE,
  output logic [7:0] RDATA,
  // Global controls
  input wire logic SLEEP_CLAMP,
  input wire logic GLOBAL_PULLUP_DISABLE,
  // Owning peripherals
  input wire pao_periph_s PERIPH,
  input wire logic [7:0] TOGGLE_OVERRIDE_EN,
  output logic [7:0] RAW_PAD_INPUT,
  output logic [7:0] PIN_CHANGE_SRC,
  output logic [1:0] OSC_PATH_EN,
  // Pad side
  input wire logic [7:0] PAD_IN,
  output logic [7:0] PAD_OUT,
  output logic [7:0] PAD_OE,
  output logic [7:0] PAD_PULLUP,
  output logic [7:0] PAD_INPUT_EN
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  // Pin mapping below is wired for exactly one eight-bit port
  if (PORT_W != PAO_PORT_W) begin : g_bad_width
    $error("pao_portb: PORT_W must be 8");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] port;
    logic [7:0] sync1;
    logic [7:0] pin;
    logic [7:0] rdata;
    logic [7:0] raw;
    logic [7:0] pc_src;
    logic [1:0] osc;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pu;
    logic [7:0] pad_ie;
  } pao_state_s;

  pao_state_s q;
  pao_state_s d;
  pao_ovr_s ovr [8];
  logic [7:0] clk_pin;
  logic timer_osc_out;
  logic timer_osc_in;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Override set of one pin as its owning peripheral produces it
  function automatic pao_ovr_s owner_ovr(input int idx,
                                         input pao_periph_s p,
                                         input logic port_bit,
                                         input logic global_pullup_disable,
                                         input logic clk_b);
    pao_ovr_s o;
    logic slave;
    logic master;
    logic pc_on;
    o = '0;
    slave = p.spi_en & ~p.spi_master;
    master = p.spi_en & p.spi_master;
    pc_on = p.pc_mask[idx] & p.pc_group_en;
    o.input_en_override_en = pc_on;
    o.input_en_override_val = 1'b1;
    case (idx)
      PAO_PB_OSC_OUT, PAO_PB_OSC_IN: begin
        // Clock pin: pull-up and driver held off
        o.pullup_override_en = clk_b;
        o.dir_override_en = clk_b;
        o.input_en_override_en = clk_b | pc_on;
        // Clock pins feed the oscillator, not the digital input
        o.input_en_override_val = ~clk_b;
      end
      PAO_PB_SCK: begin
        o.pullup_override_en = slave;
        o.pullup_override_val = port_bit & ~global_pullup_disable;
        o.dir_override_en = slave;
        o.value_override_en = master;
        o.value_override_val = p.sck_out;
      end
      PAO_PB_MISO: begin
        o.pullup_override_en = master;
        o.pullup_override_val = port_bit & ~global_pullup_disable;
        o.dir_override_en = master;
        o.value_override_en = slave;
        o.value_override_val = p.miso_out;
      end
      PAO_PB_MOSI: begin
        o.pullup_override_en = slave;
        o.pullup_override_val = port_bit & ~global_pullup_disable;
        o.dir_override_en = slave;
        // Compare output shows only once software sets the direction bit
        o.value_override_en = master | p.t2_cmp_en;
        o.value_override_val = (master & p.mosi_out)
                               | (p.t2_cmp_en & p.t2_cmp_out);
      end
      default: begin
        o.input_en_override_val = 1'b1;
      end
    endcase
    return o;
  endfunction : owner_ovr

  // Resolve pad controls from overrides and port bits
  function automatic pao_pad_s resolve(input pao_ovr_s o,
                                       input logic dir_b,
                                       input logic port_b,
                                       input logic global_pullup_disable,
                                       input logic sleep);
    pao_pad_s r;
    r.oe = o.dir_override_en ? o.dir_override_val : dir_b;
    r.out = o.value_override_en ? o.value_override_val
                                : (port_b ^ o.toggle_override_en);
    r.pu = o.pullup_override_en ? o.pullup_override_val
                                : (~dir_b & port_b & ~global_pullup_disable);
    r.ie = o.input_en_override_en ? o.input_en_override_val
                                  : ~sleep;
    return r;
  endfunction : resolve

  // ----------------------------------------------------------------------
  // Clock-pin selection and override sets
  // ----------------------------------------------------------------------
  // Chip oscillator uses bit 6 unless the internal RC clock runs
  always_comb begin
    timer_osc_in = PERIPH.intrc & PERIPH.async_t2;
    timer_osc_out = timer_osc_in & ~PERIPH.ext_clk;
    clk_pin = PAO_ZERO;
    clk_pin[PAO_PB_OSC_IN] = ~PERIPH.intrc | timer_osc_in;
    // External clock drives bit 6 only, so bit 7 stays free then
    clk_pin[PAO_PB_OSC_OUT] = (~PERIPH.intrc & ~PERIPH.extck)
                              | timer_osc_out;
  end

  // Owner overrides ORed with the generic toggle request per pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ovr[i] = owner_ovr(i, PERIPH, q.port[i], GLOBAL_PULLUP_DISABLE,
                         clk_pin[i]);
      ovr[i].toggle_override_en = ovr[i].toggle_override_en
                                  | TOGGLE_OVERRIDE_EN[i];
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    pao_pad_s pad;
    pad = '0;
    d = q;
    // Port write first, then pin-input toggle on top of it
    if (DIR_WRITE_STROBE) begin
      d.dir = WDATA;
    end
    if (PORT_WRITE_STROBE) begin
      d.port = WDATA;
    end
    if (PIN_WRITE_STROBE) begin
      d.port = d.port ^ WDATA;
    end
    for (int i = 0; i < 8; i++) begin
      pad = resolve(ovr[i], q.dir[i], q.port[i], GLOBAL_PULLUP_DISABLE,
                    SLEEP_CLAMP);
      d.pad_oe[i] = pad.oe;
      d.pad_out[i] = pad.out;
      d.pad_pu[i] = pad.pu;
      d.pad_ie[i] = pad.ie;
      // Clamp ahead of the synchronizer, as the Schmitt input does
      d.raw[i] = PAD_IN[i] & pad.ie;
    end
    // Two stages; the first is read only by the second
    d.sync1 = d.raw;
    d.pin = q.sync1;
    d.pc_src = PAO_ZERO;
    d.pc_src[7:PAO_PC_LO] = d.raw[7:PAO_PC_LO];
    d.osc = clk_pin[PAO_PB_OSC_OUT:PAO_PB_OSC_IN];
    // Clock pins hide their bits from software
    if (DIR_READ_STROBE | PORT_READ_STROBE | PIN_READ_STROBE) begin
      d.rdata = ((DIR_READ_STROBE ? q.dir : PAO_ZERO)
                | (PORT_READ_STROBE ? q.port : PAO_ZERO)
                | (PIN_READ_STROBE ? q.pin : PAO_ZERO))
                & ~clk_pin;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.dir <= PAO_DIR_RST;
      q.port <= PAO_PORT_RST;
      q.pin <= PAO_PIN_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign RDATA = q.rdata;
  assign RAW_PAD_INPUT = q.raw;
  assign PIN_CHANGE_SRC = q.pc_src;
  assign OSC_PATH_EN = q.osc;
  assign PAD_OUT = q.pad_out;
  assign PAD_OE = q.pad_oe;
  assign PAD_PULLUP = q.pad_pu;
  assign PAD_INPUT_EN = q.pad_ie;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  property p_pu_ovr;
    ovr[PAO_PB_SCK].pullup_override_en |=>
      PAD_PULLUP[PAO_PB_SCK] == $past(ovr[PAO_PB_SCK].pullup_override_val);
  endproperty
  a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up override");

  property p_pu_plain;
    1'b1 |=> PAD_PULLUP[0] == (~$past(q.dir[0]) & $past(q.port[0])
      & ~$past(GLOBAL_PULLUP_DISABLE));
  endproperty
  a_pu_plain: assert property (p_pu_plain) else $error("plain pull-up");

  property p_dir_ovr;
    ovr[PAO_PB_MOSI].dir_override_en |=> !PAD_OE[PAO_PB_MOSI];
  endproperty
  a_dir_ovr: assert property (p_dir_ovr) else $error("dir override");

  property p_sck_slave;
    PERIPH.spi_en && !PERIPH.spi_master |=> !PAD_OE[PAO_PB_SCK];
  endproperty
  a_sck_slave: assert property (p_sck_slave) else $error("sck forced");

  property p_miso_master;
    PERIPH.spi_en && PERIPH.spi_master |=> !PAD_OE[PAO_PB_MISO];
  endproperty
  a_miso_master: assert property (p_miso_master)
    else $error("miso forced");

  property p_clk_read;
    clk_pin[PAO_PB_OSC_OUT] && DIR_READ_STROBE |=> !RDATA[PAO_PB_OSC_OUT];
  endproperty
  a_clk_read: assert property (p_clk_read) else $error("clock pin read");

  property p_toggle;
    PIN_WRITE_STROBE && !PORT_WRITE_STROBE |=>
      q.port == ($past(q.port) ^ $past(WDATA));
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin toggle");

  property p_sleep;
    SLEEP_CLAMP && !ovr[0].input_en_override_en |=>
      !PAD_INPUT_EN[0] && !RAW_PAD_INPUT[0];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clamp");

  property p_pc_src;
    1'b1 |=> PIN_CHANGE_SRC[7:3] == RAW_PAD_INPUT[7:3];
  endproperty
  a_pc_src: assert property (p_pc_src) else $error("pin change src");

  property p_pin_path;
    !SLEEP_CLAMP && !PERIPH.spi_en && !TOGGLE_OVERRIDE_EN[0]
      ##1 PIN_READ_STROBE |=> RDATA[0] == $past(PAD_IN[0], 3);
  endproperty
  a_pin_path: assert property (p_pin_path) else $error("pin sync path");

  c_spi_slave: cover property (PERIPH.spi_en && !PERIPH.spi_master);
  c_timer_osc: cover property (timer_osc_out ##1 OSC_PATH_EN[1]);
  c_toggle: cover property (PIN_WRITE_STROBE ##1 PAD_OUT != $past(PAD_OUT));

endmodule : pao_portb
